// ===== bpss_pkg.sv
// constants and types shared by the bridge steering and shutdown stage
package bpss_pkg;

  // register byte offsets on the avalon slave
  localparam logic [3:0] BPSS_ADDR_DEAD_BAND = 4'h0;
  localparam logic [3:0] BPSS_ADDR_FAULT = 4'h4;
  localparam logic [3:0] BPSS_ADDR_MODE = 4'h8;

  // values after reset
  localparam logic [7:0] BPSS_DEAD_BAND_RESET = 8'h00;
  localparam logic [7:0] BPSS_FAULT_RESET = 8'h00;
  localparam logic [1:0] BPSS_MODE_RESET = 2'h0;

  // dead_band_restart_config fields
  localparam int BPSS_RESTART_BIT = 7;
  localparam int BPSS_COUNT_MSB = 6;
  // fault_shutdown_control fields
  localparam int BPSS_FLAG_BIT = 7;
  localparam int BPSS_SRC_MSB = 6;
  localparam int BPSS_SRC_LSB = 4;
  localparam int BPSS_AC_MSB = 3;
  localparam int BPSS_AC_LSB = 2;
  localparam int BPSS_BD_MSB = 1;
  localparam int BPSS_BD_LSB = 0;
  // pwm_mode_control: bit 1 is direction_select in the full-bridge modes
  localparam int BPSS_DIR_BIT = 1;

  // shutdown source vector positions {fault pin, comparator 2, comparator 1}
  localparam int BPSS_SRC_CMP1 = 0;
  localparam int BPSS_SRC_CMP2 = 1;
  localparam int BPSS_SRC_FAULT = 2;

  // one instruction_cycle is one clock; prescale values in instruction cycles
  localparam logic [4:0] BPSS_PRESC_CYC_1 = 5'h01;
  localparam logic [4:0] BPSS_PRESC_CYC_4 = 5'h04;
  localparam logic [4:0] BPSS_PRESC_CYC_16 = 5'h10;

  typedef enum logic [1:0] {
    BPSS_SINGLE = 2'b00,
    BPSS_FULL_FWD = 2'b01,
    BPSS_HALF = 2'b10,
    BPSS_FULL_REV = 2'b11
  } bpss_mode_type;

  typedef enum logic [1:0] {
    BPSS_SAFE_LOW = 2'b00,
    BPSS_SAFE_HIGH = 2'b01,
    BPSS_SAFE_TRI = 2'b10
  } bpss_safe_type;

endpackage

// ===== bpss_core_if.sv
// signals between the steering core and its dead-band and shutdown helpers
`timescale 1ns/1ps
`default_nettype none
interface bpss_core_if;
  logic [6:0] dead_count;
  logic [1:0] wave_in;
  logic [1:0] wave_dly;
  logic [2:0] src_sync;
  logic [2:0] src_sel;
  logic restart;
  logic sw_wr;
  logic sw_val;
  logic cond;
  logic flag;
  modport db (input dead_count, input wave_in, output wave_dly);
  modport sd (input src_sync, input src_sel, input restart, input sw_wr, input sw_val, output cond, output flag);
  modport core (output dead_count, output wave_in, output src_sync, output src_sel, output restart,
                output sw_wr, output sw_val, input wave_dly, input cond, input flag);
endinterface
`default_nettype wire

// ===== bpss_dead_band.sv
// active-going edge delay for the two half-bridge outputs
`timescale 1ns/1ps
`default_nettype none
module bpss_dead_band
  import bpss_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // core side
  bpss_core_if.db db
);

  for (genvar i = 0; i < 2; i++) begin : g_chan
    logic [6:0] cnt_q;
    logic out_q;
    // reload while inactive so a fresh active edge always waits the full count
    always_ff @(posedge clk) begin
      if (reset) begin
        cnt_q <= 7'h00;
        out_q <= 1'b0;
      end else if (!db.wave_in[i]) begin
        cnt_q <= db.dead_count;
        out_q <= 1'b0;
      end else if (cnt_q == 7'h00) begin
        out_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q - 7'h01;
      end
    end
    assign db.wave_dly[i] = out_q;

    a_fall_no_delay: assert property (@(posedge clk) disable iff (reset)
      !db.wave_in[i] |=> !out_q) else $error("dead band delayed an inactive-going edge");
    a_rise_after_count: assert property (@(posedge clk) disable iff (reset)
      ($rose(db.wave_in[i]) && db.dead_count == 7'h02 && $stable(db.dead_count))
      |=> !out_q ##1 (!out_q || !db.wave_in[i]) ##1 (out_q || !db.wave_in[i]))
      else $error("dead band count not honoured");
  end

endmodule
`default_nettype wire

// ===== bpss_shutdown.sv
// shutdown status flag: hardware set, auto restart, firmware set and clear
`timescale 1ns/1ps
`default_nettype none
module bpss_shutdown
  import bpss_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // core side
  bpss_core_if.sd sd
);

  logic flag_q;
  logic flag_d;

  assign sd.cond = |(sd.src_sel & sd.src_sync);

  // a present condition wins over any write or restart, so no event is lost
  always_comb begin
    flag_d = flag_q;
    if (sd.cond) begin
      flag_d = 1'b1;
    end else if (sd.sw_wr) begin
      flag_d = sd.sw_val;
    end else if (sd.restart) begin
      flag_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end
  assign sd.flag = flag_q;

  a_cond_sets_flag: assert property (@(posedge clk) disable iff (reset)
    sd.cond |=> flag_q) else $error("shutdown condition did not set the flag");
  a_write_ignored: assert property (@(posedge clk) disable iff (reset)
    (sd.cond && sd.sw_wr && !sd.sw_val) |=> flag_q) else $error("flag cleared during condition");
  a_auto_restart: assert property (@(posedge clk) disable iff (reset)
    (sd.restart && flag_q && !sd.cond && !sd.sw_wr) |=> !flag_q) else $error("auto restart did not clear flag");
  a_manual_restart: assert property (@(posedge clk) disable iff (reset)
    (!sd.restart && flag_q && !sd.sw_wr) |=> flag_q) else $error("flag cleared without firmware");
  a_force_flag: assert property (@(posedge clk) disable iff (reset)
    (sd.sw_wr && sd.sw_val) |=> flag_q) else $error("firmware set of flag lost");

endmodule
`default_nettype wire

// ===== bpss_top.sv
// bridge pwm steering, dead band and fault auto-shutdown with avalon registers
//
// The implementer's own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - full bridge uses four outputs but only two are active at once.
// - forward: A held active, D modulated, B and C inactive.
// - reverse: C held active, B modulated, A and D inactive.
// - direction bit may change anytime; steering follows from next period.
// - on direction change, swap and blank outputs one prescale interval early.
// - modulated outputs B and D stay inactive from the swap until period start.
// - full bridge inserts no dead band on any transition.
// - half bridge delays only inactive-to-active edges.
// - seven-bit count gives the delay in instruction cycles.
// - a selected shutdown event puts enabled outputs into their shutdown state.
// - three-bit source field picks comparators and fault pin combinations.
// - shutdown forces the pins asynchronously, without waiting for a clock.
// - per pair safe state: 00 low, 01 high, 1x tri-state.
// - hardware sets the status flag on an event; flag holds shutdown.
// - with restart on, the flag clears itself when the event is gone.
// - with restart off, the flag stays set until firmware clears it.
// - flag set at period start keeps shutdown for that period; resume at next start.
// - firmware writes to the flag are ignored while a condition is present.
// - comparator causes act as levels; flag cannot clear while they persist.
// - firmware writing one to the flag forces shutdown like an event.
// - period boundary comes from the timer and restarts the waveform.
module bpss_top
  import bpss_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET,
  // avalon-mm slave
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // period timer and duty compare
  input wire logic PERIOD_START,
  input wire logic TIMER_EQ_PERIOD,
  input wire logic [1:0] TIMER_PRESCALE_SELECT,
  input wire logic PWM_RAW,
  // shutdown sources
  input wire logic COMPARATOR_1_OUT,
  input wire logic COMPARATOR_2_OUT,
  input wire logic FAULT_INPUT_PIN,
  // bridge outputs, enable low while driving
  output logic BRIDGE_OUT_A,
  output logic BRIDGE_OUT_A_OE_N,
  output logic BRIDGE_OUT_B,
  output logic BRIDGE_OUT_B_OE_N,
  output logic BRIDGE_OUT_C,
  output logic BRIDGE_OUT_C_OE_N,
  output logic BRIDGE_OUT_D,
  output logic BRIDGE_OUT_D_OE_N
);

  bpss_core_if core_if ();

  logic [7:0] dead_cfg_q;
  logic [6:0] fault_cfg_q;
  bpss_mode_type mode_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic wr_take;
  logic [2:0] src_meta_q;
  logic [2:0] src_sync_q;
  logic [2:0] src_raw;
  logic cond_async;
  logic dir_run_q;
  logic eq_q;
  logic early_q;
  logic early_go;
  logic [4:0] early_cnt_q;
  logic [4:0] presc_cyc;
  logic hold_q;
  logic [3:0] out_d;
  logic [3:0] out_q;
  logic shut;
  logic [1:0] safe_ac;
  logic [1:0] safe_bd;
  logic full_mode;
  logic dir_eff;
  logic mod_wave;

  // ---------------- avalon slave: one wait state on every access
  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack_q;
  assign wr_take = AVS_WRITE && ack_q && AVS_BYTEENABLE[0];
  assign AVS_READDATA = rdata_q;

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (AVS_READ || AVS_WRITE) && !ack_q;
    end
  end

  // read data is latched in the wait cycle and stands while waitrequest is low
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      rdata_q <= 32'h0000_0000;
    end else if (AVS_READ && !ack_q) begin
      case (AVS_ADDRESS)
        BPSS_ADDR_DEAD_BAND: rdata_q <= {24'h00_0000, dead_cfg_q};
        BPSS_ADDR_FAULT: rdata_q <= {24'h00_0000, core_if.flag, fault_cfg_q};
        BPSS_ADDR_MODE: rdata_q <= {30'h0000_0000, mode_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      dead_cfg_q <= BPSS_DEAD_BAND_RESET;
    end else if (wr_take && AVS_ADDRESS == BPSS_ADDR_DEAD_BAND) begin
      dead_cfg_q <= AVS_WRITEDATA[7:0];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      fault_cfg_q <= BPSS_FAULT_RESET[6:0];
    end else if (wr_take && AVS_ADDRESS == BPSS_ADDR_FAULT) begin
      fault_cfg_q <= AVS_WRITEDATA[6:0];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      mode_q <= bpss_mode_type'(BPSS_MODE_RESET);
    end else if (wr_take && AVS_ADDRESS == BPSS_ADDR_MODE) begin
      mode_q <= bpss_mode_type'(AVS_WRITEDATA[1:0]);
    end
  end

  // ---------------- shutdown sources
  assign src_raw = {FAULT_INPUT_PIN, COMPARATOR_2_OUT, COMPARATOR_1_OUT};

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      src_meta_q <= 3'h0;
      src_sync_q <= 3'h0;
    end else begin
      src_meta_q <= src_raw;
      src_sync_q <= src_meta_q;
    end
  end

  // the unsynchronised path exists only to force the pins without a clock edge;
  // the flag itself is fed from the synchronised copy
  assign cond_async = |(fault_cfg_q[BPSS_SRC_MSB:BPSS_SRC_LSB] & src_raw);

  assign core_if.src_sync = src_sync_q;
  assign core_if.src_sel = fault_cfg_q[BPSS_SRC_MSB:BPSS_SRC_LSB];
  assign core_if.restart = dead_cfg_q[BPSS_RESTART_BIT];
  assign core_if.sw_wr = wr_take && AVS_ADDRESS == BPSS_ADDR_FAULT;
  assign core_if.sw_val = AVS_WRITEDATA[BPSS_FLAG_BIT];

  bpss_shutdown u_shutdown (
    .clk(CLK_SYS),
    .reset(RESET),
    .sd(core_if.sd)
  );

  // once the flag was seen, shutdown lasts until a boundary finds it clear
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      hold_q <= 1'b0;
    end else if (core_if.flag) begin
      hold_q <= 1'b1;
    end else if (PERIOD_START) begin
      hold_q <= 1'b0;
    end
  end

  // ---------------- direction steering
  assign full_mode = (mode_q == BPSS_FULL_FWD) || (mode_q == BPSS_FULL_REV);

  always_comb begin
    case (TIMER_PRESCALE_SELECT)
      2'b00: presc_cyc = BPSS_PRESC_CYC_1;
      2'b01: presc_cyc = BPSS_PRESC_CYC_4;
      default: presc_cyc = BPSS_PRESC_CYC_16;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      dir_run_q <= 1'b0;
    end else if (PERIOD_START) begin
      dir_run_q <= mode_q[BPSS_DIR_BIT];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      eq_q <= 1'b0;
    end else begin
      eq_q <= TIMER_EQ_PERIOD;
    end
  end

  // the window opens in the first eq cycle itself, so the pins see a whole prescale interval
  assign early_go = TIMER_EQ_PERIOD && !eq_q && full_mode && mode_q[BPSS_DIR_BIT] != dir_run_q;

  // the last timer count lasts one prescale interval, so its first cycle is the early point;
  // the prescale count also ends the window if the boundary strobe is late
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      early_q <= 1'b0;
      early_cnt_q <= 5'h00;
    end else if (PERIOD_START || (early_q && early_cnt_q == presc_cyc)) begin
      early_q <= 1'b0;
      early_cnt_q <= 5'h00;
    end else if (early_go) begin
      early_q <= 1'b1;
      early_cnt_q <= 5'h01;
    end else if (early_q) begin
      early_cnt_q <= early_cnt_q + 5'h01;
    end
  end

  // half bridge drives a and its complement on b through the dead band
  assign core_if.dead_count = dead_cfg_q[BPSS_COUNT_MSB:0];
  assign core_if.wave_in = {!PWM_RAW, PWM_RAW};

  bpss_dead_band u_dead_band (
    .clk(CLK_SYS),
    .reset(RESET),
    .db(core_if.db)
  );

  assign dir_eff = (early_q || early_go) ? mode_q[BPSS_DIR_BIT] : dir_run_q;
  // the boundary cycle already carries the new period's first pulse, so it is not blanked
  assign mod_wave = PWM_RAW && !((early_q || early_go) && !PERIOD_START);

  // out_d bit order is {d, c, b, a}; full bridge skips the dead band entirely
  always_comb begin
    out_d = 4'h0;
    case (mode_q)
      BPSS_SINGLE: out_d = {3'b000, PWM_RAW};
      BPSS_HALF: out_d = {2'b00, core_if.wave_dly[1], core_if.wave_dly[0]};
      BPSS_FULL_FWD, BPSS_FULL_REV: begin
        if (!dir_eff) begin
          out_d = {mod_wave, 1'b0, 1'b0, 1'b1};
        end else begin
          out_d = {1'b0, 1'b1, mod_wave, 1'b0};
        end
      end
      default: out_d = 4'h0;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      out_q <= 4'h0;
    end else begin
      out_q <= out_d;
    end
  end

  // ---------------- pin stage: the shutdown override is combinational on purpose
  assign shut = cond_async || core_if.flag || hold_q;
  assign safe_ac = fault_cfg_q[BPSS_AC_MSB:BPSS_AC_LSB];
  assign safe_bd = fault_cfg_q[BPSS_BD_MSB:BPSS_BD_LSB];

  always_comb begin
    BRIDGE_OUT_A = out_q[0];
    BRIDGE_OUT_B = out_q[1];
    BRIDGE_OUT_C = out_q[2];
    BRIDGE_OUT_D = out_q[3];
    BRIDGE_OUT_A_OE_N = 1'b0;
    BRIDGE_OUT_B_OE_N = 1'b0;
    BRIDGE_OUT_C_OE_N = 1'b0;
    BRIDGE_OUT_D_OE_N = 1'b0;
    if (shut) begin
      BRIDGE_OUT_A = safe_ac[0] && !safe_ac[1];
      BRIDGE_OUT_C = safe_ac[0] && !safe_ac[1];
      BRIDGE_OUT_B = safe_bd[0] && !safe_bd[1];
      BRIDGE_OUT_D = safe_bd[0] && !safe_bd[1];
      BRIDGE_OUT_A_OE_N = safe_ac[1];
      BRIDGE_OUT_C_OE_N = safe_ac[1];
      BRIDGE_OUT_B_OE_N = safe_bd[1];
      BRIDGE_OUT_D_OE_N = safe_bd[1];
    end
  end

  // ---------------- checks
  a_two_active: assert property (@(posedge CLK_SYS) disable iff (RESET)
    $past(full_mode) |-> (out_q[0] ^ out_q[2]) && $countones(out_q) <= 2)
    else $error("more than two bridge outputs active");

  a_forward_steer: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (full_mode && !dir_run_q && !early_q && !early_go)
    |=> (out_q[0] && !out_q[1] && !out_q[2] && out_q[3] == $past(PWM_RAW)))
    else $error("forward steering wrong");

  a_reverse_steer: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (full_mode && dir_run_q && !early_q && !early_go)
    |=> (out_q[2] && !out_q[0] && !out_q[3] && out_q[1] == $past(PWM_RAW)))
    else $error("reverse steering wrong");

  a_dir_at_boundary: assert property (@(posedge CLK_SYS) disable iff (RESET)
    !PERIOD_START |=> $stable(dir_run_q)) else $error("direction applied off the boundary");

  a_early_blank: assert property (@(posedge CLK_SYS) disable iff (RESET)
    ((early_q || early_go) && full_mode && !PERIOD_START) |=> (!out_q[1] && !out_q[3]))
    else $error("modulated output active in early window");

  a_early_bounded: assert property (@(posedge CLK_SYS) disable iff (RESET)
    $rose(early_q) |-> ##[1:16] !early_q) else $error("early window longer than a prescale interval");

  a_early_swaps: assert property (@(posedge CLK_SYS) disable iff (RESET)
    early_go |=> (out_q[0] == !$past(mode_q[BPSS_DIR_BIT]) && out_q[2] == $past(mode_q[BPSS_DIR_BIT])))
    else $error("unmodulated pair not swapped");

  a_safe_low_ac: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (shut && safe_ac == BPSS_SAFE_LOW) |-> (!BRIDGE_OUT_A && !BRIDGE_OUT_C && !BRIDGE_OUT_A_OE_N))
    else $error("pair a/c not driven low in shutdown");

  a_safe_tri_bd: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (shut && safe_bd[1]) |-> (BRIDGE_OUT_B_OE_N && BRIDGE_OUT_D_OE_N)) else $error("pair b/d not released");

  a_async_force: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (cond_async && safe_ac == BPSS_SAFE_HIGH)
    |-> (BRIDGE_OUT_A && BRIDGE_OUT_C && !BRIDGE_OUT_A_OE_N && !BRIDGE_OUT_C_OE_N))
    else $error("shutdown source did not force pins at once");

  a_source_off: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (fault_cfg_q[BPSS_SRC_MSB:BPSS_SRC_LSB] == 3'b000) |-> (!cond_async && !core_if.cond))
    else $error("disabled source field still triggers shutdown");

  a_safe_tri_ac: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (shut && safe_ac[1]) |-> (BRIDGE_OUT_A_OE_N && BRIDGE_OUT_C_OE_N)) else $error("pair a/c not released");

  a_safe_high_bd: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (shut && safe_bd == BPSS_SAFE_HIGH)
    |-> (BRIDGE_OUT_B && BRIDGE_OUT_D && !BRIDGE_OUT_B_OE_N && !BRIDGE_OUT_D_OE_N))
    else $error("pair b/d not driven high in shutdown");

  a_hold_period: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (hold_q && !PERIOD_START) |=> hold_q) else $error("shutdown released inside a period");

  a_hold_release: assert property (@(posedge CLK_SYS) disable iff (RESET)
    $fell(hold_q) |-> ($past(PERIOD_START) && !$past(core_if.flag)))
    else $error("shutdown left off a period start");

  a_reset_clear: assert property (@(posedge CLK_SYS)
    RESET |=> (dead_cfg_q == 8'h00 && fault_cfg_q == 7'h00)) else $error("registers not cleared by reset");

endmodule
`default_nettype wire

// ===== bpss_bridge_model.sv
// far-side model: gate drivers with pull-downs and the three shutdown sources
`timescale 1ns/1ps
`default_nettype none
module bpss_bridge_model (
  // design outputs, enable low while driving
  input wire logic [3:0] drive,
  input wire logic [3:0] oe_n,
  // source commands {fault pin, comparator 2, comparator 1}
  input wire logic [2:0] src_cmd,
  // resolved gate lines and source lines
  output logic [3:0] gate,
  output logic cmp1,
  output logic cmp2,
  output logic fault_pin
);
  // a released pair falls to the pull-down, so the switches stay off
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      gate[i] = oe_n[i] ? 1'b0 : drive[i];
    end
  end
  // sources are levels; they stay up as long as the bench holds the cause
  assign cmp1 = src_cmd[0];
  assign cmp2 = src_cmd[1];
  assign fault_pin = src_cmd[2];
endmodule
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the bridge steering and shutdown stage
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import bpss_pkg::*;
  localparam int PER = 40;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic period_start = 1'b0;
  logic timer_eq = 1'b0;
  logic [1:0] presc = 2'h0;
  logic pwm_raw = 1'b0;
  logic [2:0] src_cmd = 3'h0;
  wire logic cmp1;
  wire logic cmp2;
  wire logic fault_pin;
  wire logic [3:0] drive;
  wire logic [3:0] oe_n;
  wire logic [3:0] gate;
  int cnt = 0;
  int duty = 8;
  int miscompares = 0;
  int checked = 0;

  always #4 clk_sys = ~clk_sys;

  // period timer stand-in: eq level for one prescale interval, then the boundary pulse
  always @(posedge clk_sys) begin
    cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
    period_start <= (cnt == PER - 1);
    timer_eq <= (cnt >= PER - 1 - ((presc == 2'h0) ? 1 : (presc == 2'h1) ? 4 : 16)) && (cnt != PER - 1);
    pwm_raw <= (((cnt == PER - 1) ? 0 : cnt + 1) < duty);
  end

  bpss_top dut_u (
    .CLK_SYS(clk_sys), .RESET(reset),
    .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
    .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
    .PERIOD_START(period_start), .TIMER_EQ_PERIOD(timer_eq),
    .TIMER_PRESCALE_SELECT(presc), .PWM_RAW(pwm_raw),
    .COMPARATOR_1_OUT(cmp1), .COMPARATOR_2_OUT(cmp2), .FAULT_INPUT_PIN(fault_pin),
    .BRIDGE_OUT_A(drive[0]), .BRIDGE_OUT_A_OE_N(oe_n[0]),
    .BRIDGE_OUT_B(drive[1]), .BRIDGE_OUT_B_OE_N(oe_n[1]),
    .BRIDGE_OUT_C(drive[2]), .BRIDGE_OUT_C_OE_N(oe_n[2]),
    .BRIDGE_OUT_D(drive[3]), .BRIDGE_OUT_D_OE_N(oe_n[3])
  );

  bpss_bridge_model partner_u (
    .drive(drive), .oe_n(oe_n), .src_cmd(src_cmd),
    .gate(gate), .cmp1(cmp1), .cmp2(cmp2), .fault_pin(fault_pin)
  );

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // samples are taken just after the edge, so they show the cycle that edge closed
  task automatic bus(input logic [3:0] a, input logic wr, input logic [7:0] wd, output logic [7:0] rd);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h00_0000, wd};
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
    if (n >= 20) begin
      miscompares++;
      summarize();
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] x;
    bus(a, 1'b1, d, x);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] x;
    bus(a, 1'b0, 8'h00, x);
    check(x, e);
  endtask

  // which 0 waits for the boundary pulse, 1 for the eq level
  task automatic wait_for(input int which);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (((which == 0) ? period_start : timer_eq) !== 1'b1 && n < 100);
    if (n >= 100) begin
      miscompares++;
      summarize();
    end
  endtask

  task automatic t_reset;
    rd_chk(BPSS_ADDR_DEAD_BAND, 8'h00);
    rd_chk(BPSS_ADDR_FAULT, 8'h00);
    rd_chk(BPSS_ADDR_MODE, 8'h00);
    wr(4'hc, 8'hff);
    rd_chk(4'hc, 8'h00);
    avs_byteenable <= 4'he;
    wr(BPSS_ADDR_DEAD_BAND, 8'h55);
    avs_byteenable <= 4'hf;
    rd_chk(BPSS_ADDR_DEAD_BAND, 8'h00);
  endtask

  task automatic t_half;
    logic [3:0] exp;
    for (int d = 0; d < 4; d += 2) begin
      wr(BPSS_ADDR_DEAD_BAND, d[7:0]);
      wr(BPSS_ADDR_MODE, 8'h02);
      wait_for(0);
      for (int k = 1; k < PER; k++) begin
        @(posedge clk_sys);
        // dead band flop plus output flop: two cycles of latency, b still high in the first cycle
        exp = {2'b00, (k >= duty + d + 2 || k == 1), (k >= d + 2 && k <= duty + 1)};
        check({4'h0, gate}, {4'h0, exp});
      end
    end
  endtask

  // dead band stays programmed so a delayed edge would show in full bridge
  task automatic t_full;
    logic rev_now;
    wr(BPSS_ADDR_DEAD_BAND, 8'h03);
    wr(BPSS_ADDR_MODE, 8'h01);
    duty = 8; // low duty before any reversal
    for (int i = 0; i < 4; i++) begin
      rev_now = i[0];
      presc <= (i < 2) ? 2'h1 : 2'h2;
      wait_for(0);
      tick(2);
      check({4'h0, gate}, rev_now ? 8'h06 : 8'h09);
      tick(8);
      check({4'h0, gate}, rev_now ? 8'h04 : 8'h01);
      wr(BPSS_ADDR_MODE, rev_now ? 8'h01 : 8'h03);
      check({4'h0, gate}, rev_now ? 8'h04 : 8'h01);
      wait_for(1);
      tick(2);
      check({4'h0, gate}, rev_now ? 8'h01 : 8'h04);
    end
    presc <= 2'h0;
  endtask

  task automatic t_safe;
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      wr(BPSS_ADDR_FAULT, {1'b1, 3'b000, c, c});
      tick(1);
      check({gate, oe_n}, {{4{c == 2'b01}}, {4{c[1]}}});
      rd_chk(BPSS_ADDR_FAULT, {1'b1, 3'b000, c, c});
    end
    wr(BPSS_ADDR_FAULT, 8'h00);
  endtask

  task automatic t_manual;
    wr(BPSS_ADDR_FAULT, 8'h46);
    wait_for(0);
    tick(2);
    src_cmd <= 3'h4;
    #1;
    check({gate, oe_n}, 8'h5a);
    tick(5);
    rd_chk(BPSS_ADDR_FAULT, 8'hc6);
    wr(BPSS_ADDR_FAULT, 8'h46);
    rd_chk(BPSS_ADDR_FAULT, 8'hc6);
    src_cmd <= 3'h0;
    tick(5);
    rd_chk(BPSS_ADDR_FAULT, 8'hc6);
    wait_for(0);
    wr(BPSS_ADDR_FAULT, 8'h46); // firmware restart
    check({gate, oe_n}, 8'h5a);
    wait_for(0);
    tick(2);
    check({gate, oe_n}, 8'h90);
  endtask

  // auto restart on; every source code against every single cause
  task automatic t_sources;
    logic sel;
    int n;
    wr(BPSS_ADDR_DEAD_BAND, 8'h80);
    for (int s = 0; s < 8; s++) begin
      for (int b = 0; b < 3; b++) begin
        wr(BPSS_ADDR_FAULT, {1'b0, s[2:0], 4'h0});
        sel = s[b];
        src_cmd <= 3'h1 << b;
        #1;
        check({7'h00, gate[0]}, {7'h00, !sel});
        tick(5);
        rd_chk(BPSS_ADDR_FAULT, {sel, s[2:0], 4'h0});
        src_cmd <= 3'h0;
        tick(4);
        rd_chk(BPSS_ADDR_FAULT, {1'b0, s[2:0], 4'h0});
        n = 0;
        while (gate[0] !== 1'b1 && n < 100) begin
          @(posedge clk_sys);
          n++;
        end
        check({7'h00, gate[0]}, 8'h01);
      end
    end
    wr(BPSS_ADDR_FAULT, 8'h00);
  endtask

  initial begin
    tick(2);
    reset <= 1'b0;
    tick(1);
    t_reset();
    t_half();
    t_full();
    t_safe();
    t_manual();
    t_sources();
    summarize();
  end
endmodule
`default_nettype wire
